// ===== cd8_opcode_decoder.sv
// Opcode decoder and operand fetch sequencer for an 8-bit core.
// Assumes program memory bytes and the index register share clk_sys.
//
// Overview of operation
// - Flag test updates only N and Z.
// - Opcode 9F copies index to accumulator, flags kept.
// - Opcode 8F clears I mask, halts clock.
// - Upper nibble column, lower nibble row.
// - Columns pick bit, branch, read-modify-write classes.
// - Bit branches three bytes; bit set/clear two.
// - Byte offset plus index forms address.
// - Word offset, high first, plus index.
// - Absolute address high then low, three bytes.
// - Branches two bytes three cycles; subroutine six.
`timescale 1ns/10ps
`default_nettype none
module cd8_opcode_decoder (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic fetch_valid,
    input wire logic [7:0] fetch_byte,
    input wire logic [7:0] index_reg,
    output logic fetch_ready,
    output logic insn_done,
    output logic [7:0] insn_opcode,
    output cd8_pkg::cd8_class_t insn_class,
    output cd8_pkg::cd8_mode_t insn_mode,
    output logic [1:0] insn_len,
    output logic [3:0] insn_cycles,
    output logic flag_nz_update,
    output logic imask_clear,
    output logic cpu_clk_halt,
    output logic copy_index_to_acc,
    output logic opcode_illegal,
    output logic [2:0] bit_index,
    output logic branch_if_bit_high,
    output logic [15:0] operand_addr,
    output logic [7:0] pc_offset
);
    cd8_dec_if dec ();
    cd8_map u_map (
        .dec(dec)
    );

    cd8_pkg::cd8_state_t state_q;
    cd8_pkg::cd8_state_t state_d;
    cd8_pkg::cd8_class_t cls_q;
    cd8_pkg::cd8_mode_t mode_q;
    logic ready_q;
    logic done_q;
    logic [7:0] op_q;
    logic [1:0] len_q;
    logic [1:0] left_q;
    logic [3:0] cycles_q;
    logic upd_nz_q;
    logic clr_imask_q;
    logic halt_q;
    logic copy_q;
    logic illegal_q;
    logic [2:0] bit_idx_q;
    logic bit_high_q;
    logic [7:0] b1_q;
    logic [15:0] ea_q;
    logic [7:0] pcoff_q;

    wire logic take_op;
    wire logic take_opnd;
    wire logic last_opnd;
    wire logic single;
    wire logic finish;
    wire logic [7:0] opnd1;
    wire cd8_pkg::cd8_mode_t mode_now;
    wire logic [15:0] ea_d;
    wire logic [7:0] pcoff_d;

    assign dec.opcode = fetch_byte;
    assign take_op = ready_q && fetch_valid && state_q == cd8_pkg::CD8_ST_OPCODE;
    assign take_opnd = ready_q && fetch_valid && state_q == cd8_pkg::CD8_ST_OPERAND;
    assign last_opnd = take_opnd && left_q == 2'h1;
    assign single = take_op && dec.len == cd8_pkg::CD8_LEN_1;
    assign finish = single || last_opnd;
    // Three-byte instructions hold their first operand byte: the high byte, or the direct address for bit branches
    assign opnd1 = len_q == cd8_pkg::CD8_LEN_3 ? b1_q : fetch_byte;
    assign mode_now = take_op ? dec.mode : mode_q;
    assign ea_d = (mode_now == cd8_pkg::CD8_DIRECT_MODE
            || mode_now == cd8_pkg::CD8_DIRECT_PC_OFFSET) ? {8'h00, opnd1}
        : mode_now == cd8_pkg::CD8_ABSOLUTE_16_MODE ? {opnd1, fetch_byte}
        : mode_now == cd8_pkg::CD8_INDEXED_BYTE_OFFSET
            ? {8'h00, index_reg} + {8'h00, opnd1}
        : mode_now == cd8_pkg::CD8_INDEXED_WORD_OFFSET
            ? {opnd1, fetch_byte} + {8'h00, index_reg}
        : mode_now == cd8_pkg::CD8_INDEXED_NO_OFFSET ? {8'h00, index_reg}
        : 16'h0000;
    assign pcoff_d = mode_now == cd8_pkg::CD8_PC_OFFSET_MODE ? opnd1
        : mode_now == cd8_pkg::CD8_DIRECT_PC_OFFSET ? fetch_byte
        : 8'h00;
    assign state_d = (take_op && !single) ? cd8_pkg::CD8_ST_OPERAND
        : last_opnd ? cd8_pkg::CD8_ST_OPCODE : state_q;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= cd8_pkg::CD8_ST_OPCODE;
            ready_q <= 1'b0;
            done_q <= 1'b0;
            left_q <= 2'h0;
            b1_q <= 8'h00;
        end else begin
            state_q <= state_d;
            ready_q <= 1'b1;
            done_q <= finish;
            if (take_op) begin
                left_q <= dec.len - cd8_pkg::CD8_LEN_1;
            end else if (take_opnd) begin
                left_q <= left_q - 2'h1;
            end
            if (take_opnd && left_q == 2'h2) begin
                b1_q <= fetch_byte;
            end
        end
    end

    // Fields hold from opcode capture until the next opcode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            op_q <= 8'h00;
            cls_q <= cd8_pkg::CD8_CLS_ILLEGAL;
            mode_q <= cd8_pkg::CD8_IMPLIED_MODE;
            len_q <= cd8_pkg::CD8_LEN_1;
            cycles_q <= 4'h0;
            bit_idx_q <= 3'h0;
            bit_high_q <= 1'b0;
        end else if (take_op) begin
            op_q <= fetch_byte;
            cls_q <= dec.cls;
            mode_q <= dec.mode;
            len_q <= dec.len;
            cycles_q <= dec.cycles;
            bit_idx_q <= dec.bit_idx;
            bit_high_q <= dec.bit_high;
        end
    end

    // Side-effect strobes and illegal flag; illegal cells raise only illegal_q
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            upd_nz_q <= 1'b0;
            clr_imask_q <= 1'b0;
            halt_q <= 1'b0;
            copy_q <= 1'b0;
            illegal_q <= 1'b0;
        end else if (take_op) begin
            upd_nz_q <= dec.upd_nz;
            clr_imask_q <= dec.clr_imask;
            halt_q <= dec.halt_clk;
            copy_q <= dec.copy_x;
            illegal_q <= dec.illegal;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ea_q <= 16'h0000;
            pcoff_q <= 8'h00;
        end else if (finish) begin
            ea_q <= ea_d;
            pcoff_q <= pcoff_d;
        end
    end

    assign fetch_ready = ready_q;
    assign insn_done = done_q;
    assign insn_opcode = op_q;
    assign insn_class = cls_q;
    assign insn_mode = mode_q;
    assign insn_len = len_q;
    assign insn_cycles = cycles_q;
    assign flag_nz_update = upd_nz_q;
    assign imask_clear = clr_imask_q;
    assign cpu_clk_halt = halt_q;
    assign copy_index_to_acc = copy_q;
    assign opcode_illegal = illegal_q;
    assign bit_index = bit_idx_q;
    assign branch_if_bit_high = bit_high_q;
    assign operand_addr = ea_q;
    assign pc_offset = pcoff_q;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    sequence s_ftest_xb_taken;
        take_op && fetch_byte == {cd8_pkg::CD8_HI_RMW_XB, cd8_pkg::CD8_LO_TEST};
    endsequence
    sequence s_copy_taken;
        take_op && fetch_byte == cd8_pkg::CD8_OP_COPY_INDEX_TO_ACC;
    endsequence
    sequence s_wait_taken;
        take_op && fetch_byte == cd8_pkg::CD8_OP_WAIT;
    endsequence

    property p_ftest_xb;
        s_ftest_xb_taken ##1 (state_q == cd8_pkg::CD8_ST_OPERAND && !fetch_valid) [*1] ##0 1'b1
            or s_ftest_xb_taken |=> upd_nz_q && cycles_q == 4'h5 && len_q == 2'h2;
    endproperty
    a_ftest_xb: assert property (p_ftest_xb) else $error("flag test decode wrong");
    property p_nz_only_ftest;
        done_q && upd_nz_q |-> op_q[3:0] == 4'hD && cls_q == cd8_pkg::CD8_CLS_RMW
            && !clr_imask_q && !copy_q;
    endproperty
    a_nz_only_ftest: assert property (p_nz_only_ftest) else $error("nz update off test");
    property p_copy;
        s_copy_taken |=> done_q && copy_q && len_q == 2'h1 && cycles_q == 4'h2
            && !upd_nz_q && !clr_imask_q;
    endproperty
    a_copy: assert property (p_copy) else $error("index copy decode wrong");
    property p_wait;
        s_wait_taken |=> done_q && clr_imask_q && halt_q && cycles_q == 4'h2 && !upd_nz_q;
    endproperty
    a_wait: assert property (p_wait) else $error("wait decode wrong");
    property p_branch_col;
        done_q && op_q[7:4] == 4'h2 |-> cls_q == cd8_pkg::CD8_CLS_BRANCH
            && mode_q == cd8_pkg::CD8_PC_OFFSET_MODE && len_q == 2'h2 && cycles_q == 4'h3;
    endproperty
    a_branch_col: assert property (p_branch_col) else $error("branch column wrong");
    property p_bit_branch;
        done_q && cls_q == cd8_pkg::CD8_CLS_BIT_BRANCH |-> op_q[7:4] == 4'h0
            && len_q == 2'h3 && cycles_q == 4'h5 && ea_q[15:8] == 8'h00;
    endproperty
    a_bit_branch: assert property (p_bit_branch) else $error("bit branch wrong");
    property p_byte_offset;
        last_opnd && mode_q == cd8_pkg::CD8_INDEXED_BYTE_OFFSET |=> done_q
            && ea_q == {8'h00, $past(index_reg)} + {8'h00, $past(fetch_byte)};
    endproperty
    a_byte_offset: assert property (p_byte_offset) else $error("byte offset addr wrong");
    property p_word_offset;
        last_opnd && mode_q == cd8_pkg::CD8_INDEXED_WORD_OFFSET |=> done_q
            && ea_q == {$past(b1_q), $past(fetch_byte)} + {8'h00, $past(index_reg)};
    endproperty
    a_word_offset: assert property (p_word_offset) else $error("word offset addr wrong");
    property p_absolute;
        last_opnd && mode_q == cd8_pkg::CD8_ABSOLUTE_16_MODE |=> done_q && len_q == 2'h3
            && ea_q == {$past(b1_q), $past(fetch_byte)};
    endproperty
    a_absolute: assert property (p_absolute) else $error("absolute addr wrong");
    property p_subroutine;
        done_q && op_q == 8'hAD |-> cycles_q == 4'h6 && cls_q == cd8_pkg::CD8_CLS_BRANCH;
    endproperty
    a_subroutine: assert property (p_subroutine) else $error("subroutine cycles wrong");
    property p_illegal;
        done_q && illegal_q |-> len_q == 2'h1 && !upd_nz_q && !halt_q && !copy_q
            && !clr_imask_q && ea_q == 16'h0000 && $past(take_op);
    endproperty
    a_illegal: assert property (p_illegal) else $error("blank cell has side effect");
endmodule
`default_nettype wire

// ===== cd8_pkg.sv
// Constants and types shared by the opcode decoder files.
// Assumes 8-bit opcodes, fetched one byte at a time.
package cd8_pkg;
    typedef enum logic [3:0] {
        CD8_IMPLIED_MODE = 4'h0,
        CD8_LITERAL_OPERAND_MODE = 4'h1,
        CD8_DIRECT_MODE = 4'h2,
        CD8_ABSOLUTE_16_MODE = 4'h3,
        CD8_INDEXED_WORD_OFFSET = 4'h4,
        CD8_INDEXED_BYTE_OFFSET = 4'h5,
        CD8_INDEXED_NO_OFFSET = 4'h6,
        CD8_PC_OFFSET_MODE = 4'h7,
        CD8_DIRECT_PC_OFFSET = 4'h8
    } cd8_mode_t;
    typedef enum logic [2:0] {
        CD8_CLS_BIT_BRANCH = 3'h0,
        CD8_CLS_BIT_SETCLR = 3'h1,
        CD8_CLS_BRANCH = 3'h2,
        CD8_CLS_RMW = 3'h3,
        CD8_CLS_CONTROL = 3'h4,
        CD8_CLS_REGMEM = 3'h5,
        CD8_CLS_ILLEGAL = 3'h6
    } cd8_class_t;
    typedef enum logic [1:0] {
        CD8_ST_OPCODE = 2'b01,
        CD8_ST_OPERAND = 2'b10
    } cd8_state_t;
    // Upper nibble selects the map column
    localparam logic [3:0] CD8_HI_BIT_BRANCH = 4'h0;
    localparam logic [3:0] CD8_HI_BIT_SETCLR = 4'h1;
    localparam logic [3:0] CD8_HI_BRANCH = 4'h2;
    localparam logic [3:0] CD8_HI_RMW_DIR = 4'h3;
    localparam logic [3:0] CD8_HI_RMW_ACC = 4'h4;
    localparam logic [3:0] CD8_HI_RMW_IDX = 4'h5;
    localparam logic [3:0] CD8_HI_RMW_XB = 4'h6;
    localparam logic [3:0] CD8_HI_RMW_XN = 4'h7;
    localparam logic [3:0] CD8_HI_CTL_A = 4'h8;
    localparam logic [3:0] CD8_HI_CTL_B = 4'h9;
    localparam logic [3:0] CD8_HI_RM_LIT = 4'hA;
    localparam logic [3:0] CD8_HI_RM_DIR = 4'hB;
    localparam logic [3:0] CD8_HI_RM_ABS = 4'hC;
    localparam logic [3:0] CD8_HI_RM_XW = 4'hD;
    localparam logic [3:0] CD8_HI_RM_XB = 4'hE;
    // Lower nibble selects the row
    localparam logic [3:0] CD8_LO_TEST = 4'hD;
    localparam logic [3:0] CD8_LO_STA = 4'h7;
    localparam logic [3:0] CD8_LO_STX = 4'hF;
    localparam logic [3:0] CD8_LO_JMP = 4'hC;
    localparam logic [3:0] CD8_LO_JSR = 4'hD;
    localparam logic [7:0] CD8_OP_COPY_INDEX_TO_ACC = 8'h9F;
    localparam logic [7:0] CD8_OP_WAIT = 8'h8F;
    localparam logic [7:0] CD8_OP_BRANCH_TO_SUBROUTINE = 8'hAD;
    localparam logic [7:0] CD8_OP_MUL = 8'h42;
    localparam logic [7:0] CD8_OP_RTI = 8'h80;
    localparam logic [7:0] CD8_OP_RTS = 8'h81;
    localparam logic [7:0] CD8_OP_SWI = 8'h83;
    // Populated rows per column, one bit per row
    localparam logic [15:0] CD8_RMW_ROWS = 16'hB7D9;
    localparam logic [15:0] CD8_CTL8_ROWS = 16'hC00B;
    localparam logic [15:0] CD8_CTL9_ROWS = 16'hBF80;
    localparam logic [15:0] CD8_LIT_ROWS = 16'h6F7F;
    // Cycle counts
    localparam logic [3:0] CD8_CYC_BIT = 4'h5;
    localparam logic [3:0] CD8_CYC_BRANCH = 4'h3;
    localparam logic [3:0] CD8_CYC_SUBR = 4'h6;
    localparam logic [3:0] CD8_CYC_IMPL = 4'h2;
    localparam logic [3:0] CD8_CYC_MUL = 4'hB;
    localparam logic [3:0] CD8_CYC_RTI = 4'h9;
    localparam logic [3:0] CD8_CYC_RTS = 4'h6;
    localparam logic [3:0] CD8_CYC_SWI = 4'hA;
    localparam logic [3:0] CD8_CYC_ILLEGAL = 4'h2;
    localparam logic [3:0] CD8_CYC_RMW_DIR = 4'h5;
    localparam logic [3:0] CD8_CYC_RMW_REG = 4'h3;
    localparam logic [3:0] CD8_CYC_RMW_XB = 4'h6;
    localparam logic [3:0] CD8_CYC_RMW_XN = 4'h5;
    localparam logic [3:0] CD8_CYC_FT_DIR = 4'h4;
    localparam logic [3:0] CD8_CYC_FT_XB = 4'h5;
    localparam logic [3:0] CD8_CYC_FT_XN = 4'h4;
    localparam logic [3:0] CD8_CYC_RM_LIT = 4'h2;
    localparam logic [3:0] CD8_CYC_RM_DIR = 4'h3;
    localparam logic [3:0] CD8_CYC_RM_ABS = 4'h4;
    localparam logic [3:0] CD8_CYC_RM_XW = 4'h5;
    localparam logic [3:0] CD8_CYC_RM_XB = 4'h4;
    localparam logic [3:0] CD8_CYC_RM_XN = 4'h3;
    localparam logic [3:0] CD8_CYC_STORE_ADD = 4'h1;
    localparam logic [3:0] CD8_CYC_JMP_SUB = 4'h1;
    localparam logic [3:0] CD8_CYC_JSR_ADD = 4'h2;
    // Instruction lengths in bytes
    localparam logic [1:0] CD8_LEN_1 = 2'h1;
    localparam logic [1:0] CD8_LEN_2 = 2'h2;
    localparam logic [1:0] CD8_LEN_3 = 2'h3;

    function automatic logic [1:0] cd8_len(input cd8_mode_t m);
        case (m)
            CD8_IMPLIED_MODE, CD8_INDEXED_NO_OFFSET: cd8_len = CD8_LEN_1;
            CD8_ABSOLUTE_16_MODE, CD8_INDEXED_WORD_OFFSET,
            CD8_DIRECT_PC_OFFSET: cd8_len = CD8_LEN_3;
            default: cd8_len = CD8_LEN_2;
        endcase
    endfunction
endpackage

// ===== cd8_dec_if.sv
// Decode bundle between the sequencer and the opcode map.
// Assumes the map is purely combinational.
`timescale 1ns/10ps
`default_nettype none
interface cd8_dec_if;
    logic [7:0] opcode;
    cd8_pkg::cd8_class_t cls;
    cd8_pkg::cd8_mode_t mode;
    logic [1:0] len;
    logic [3:0] cycles;
    logic upd_nz;
    logic clr_imask;
    logic halt_clk;
    logic copy_x;
    logic illegal;
    logic bit_high;
    logic [2:0] bit_idx;
    modport map (input opcode, output cls, mode, len, cycles, upd_nz, clr_imask,
        halt_clk, copy_x, illegal, bit_high, bit_idx);
    modport user (output opcode, input cls, mode, len, cycles, upd_nz, clr_imask,
        halt_clk, copy_x, illegal, bit_high, bit_idx);
endinterface
`default_nettype wire

// ===== cd8_map.sv
// Combinational opcode map: class, mode, length, cycles, side effects.
// Assumes the opcode on the bundle is stable while it is sampled.
`timescale 1ns/10ps
`default_nettype none
module cd8_map (
    cd8_dec_if.map dec
);
    wire logic [3:0] hi;
    wire logic [3:0] lo;
    wire logic [15:0] row_bit;
    wire logic is_rmw;
    wire logic is_ftest;
    wire logic legal;
    wire cd8_pkg::cd8_mode_t mode_w;

    assign hi = dec.opcode[7:4];
    assign lo = dec.opcode[3:0];
    assign row_bit = 16'h0001 << lo;
    assign is_rmw = hi >= cd8_pkg::CD8_HI_RMW_DIR && hi <= cd8_pkg::CD8_HI_RMW_XN;
    assign is_ftest = is_rmw && lo == cd8_pkg::CD8_LO_TEST;
    // Blank cells fall out of the row masks
    assign legal = hi <= cd8_pkg::CD8_HI_BRANCH
        || (is_rmw && ((|(cd8_pkg::CD8_RMW_ROWS & row_bit))
            || dec.opcode == cd8_pkg::CD8_OP_MUL))
        || (hi == cd8_pkg::CD8_HI_CTL_A && (|(cd8_pkg::CD8_CTL8_ROWS & row_bit)))
        || (hi == cd8_pkg::CD8_HI_CTL_B && (|(cd8_pkg::CD8_CTL9_ROWS & row_bit)))
        || (hi == cd8_pkg::CD8_HI_RM_LIT && (|(cd8_pkg::CD8_LIT_ROWS & row_bit)))
        || hi > cd8_pkg::CD8_HI_RM_LIT;

    function automatic cd8_pkg::cd8_mode_t mode_of(input logic [7:0] op);
        case (op[7:4])
            cd8_pkg::CD8_HI_BIT_BRANCH: mode_of = cd8_pkg::CD8_DIRECT_PC_OFFSET;
            cd8_pkg::CD8_HI_BIT_SETCLR, cd8_pkg::CD8_HI_RMW_DIR,
            cd8_pkg::CD8_HI_RM_DIR: mode_of = cd8_pkg::CD8_DIRECT_MODE;
            cd8_pkg::CD8_HI_BRANCH: mode_of = cd8_pkg::CD8_PC_OFFSET_MODE;
            cd8_pkg::CD8_HI_RMW_XB,
            cd8_pkg::CD8_HI_RM_XB: mode_of = cd8_pkg::CD8_INDEXED_BYTE_OFFSET;
            cd8_pkg::CD8_HI_RMW_XN: mode_of = cd8_pkg::CD8_INDEXED_NO_OFFSET;
            cd8_pkg::CD8_HI_RM_LIT: mode_of = op == cd8_pkg::CD8_OP_BRANCH_TO_SUBROUTINE
                ? cd8_pkg::CD8_PC_OFFSET_MODE : cd8_pkg::CD8_LITERAL_OPERAND_MODE;
            cd8_pkg::CD8_HI_RM_ABS: mode_of = cd8_pkg::CD8_ABSOLUTE_16_MODE;
            cd8_pkg::CD8_HI_RM_XW: mode_of = cd8_pkg::CD8_INDEXED_WORD_OFFSET;
            4'hF: mode_of = cd8_pkg::CD8_INDEXED_NO_OFFSET;
            default: mode_of = cd8_pkg::CD8_IMPLIED_MODE;
        endcase
    endfunction

    function automatic logic [3:0] rm_cyc(input logic [7:0] op);
        logic [3:0] base;
        case (op[7:4])
            cd8_pkg::CD8_HI_RM_LIT: base = cd8_pkg::CD8_CYC_RM_LIT;
            cd8_pkg::CD8_HI_RM_DIR: base = cd8_pkg::CD8_CYC_RM_DIR;
            cd8_pkg::CD8_HI_RM_ABS: base = cd8_pkg::CD8_CYC_RM_ABS;
            cd8_pkg::CD8_HI_RM_XW: base = cd8_pkg::CD8_CYC_RM_XW;
            cd8_pkg::CD8_HI_RM_XB: base = cd8_pkg::CD8_CYC_RM_XB;
            default: base = cd8_pkg::CD8_CYC_RM_XN;
        endcase
        if (op == cd8_pkg::CD8_OP_BRANCH_TO_SUBROUTINE) begin
            rm_cyc = cd8_pkg::CD8_CYC_SUBR;
        end else if (op[3:0] == cd8_pkg::CD8_LO_STA || op[3:0] == cd8_pkg::CD8_LO_STX) begin
            rm_cyc = base + cd8_pkg::CD8_CYC_STORE_ADD;
        end else if (op[3:0] == cd8_pkg::CD8_LO_JMP) begin
            rm_cyc = base - cd8_pkg::CD8_CYC_JMP_SUB;
        end else if (op[3:0] == cd8_pkg::CD8_LO_JSR) begin
            rm_cyc = base + cd8_pkg::CD8_CYC_JSR_ADD;
        end else begin
            rm_cyc = base;
        end
    endfunction

    function automatic logic [3:0] cyc_of(input logic [7:0] op, input logic ft);
        case (op[7:4])
            cd8_pkg::CD8_HI_BIT_BRANCH, cd8_pkg::CD8_HI_BIT_SETCLR: cyc_of = cd8_pkg::CD8_CYC_BIT;
            cd8_pkg::CD8_HI_BRANCH: cyc_of = cd8_pkg::CD8_CYC_BRANCH;
            cd8_pkg::CD8_HI_RMW_DIR: cyc_of = ft ? cd8_pkg::CD8_CYC_FT_DIR
                : cd8_pkg::CD8_CYC_RMW_DIR;
            cd8_pkg::CD8_HI_RMW_ACC: cyc_of = op == cd8_pkg::CD8_OP_MUL ? cd8_pkg::CD8_CYC_MUL
                : cd8_pkg::CD8_CYC_RMW_REG;
            cd8_pkg::CD8_HI_RMW_IDX: cyc_of = cd8_pkg::CD8_CYC_RMW_REG;
            cd8_pkg::CD8_HI_RMW_XB: cyc_of = ft ? cd8_pkg::CD8_CYC_FT_XB
                : cd8_pkg::CD8_CYC_RMW_XB;
            cd8_pkg::CD8_HI_RMW_XN: cyc_of = ft ? cd8_pkg::CD8_CYC_FT_XN
                : cd8_pkg::CD8_CYC_RMW_XN;
            cd8_pkg::CD8_HI_CTL_A: cyc_of = op == cd8_pkg::CD8_OP_RTI ? cd8_pkg::CD8_CYC_RTI
                : op == cd8_pkg::CD8_OP_RTS ? cd8_pkg::CD8_CYC_RTS
                : op == cd8_pkg::CD8_OP_SWI ? cd8_pkg::CD8_CYC_SWI : cd8_pkg::CD8_CYC_IMPL;
            cd8_pkg::CD8_HI_CTL_B: cyc_of = cd8_pkg::CD8_CYC_IMPL;
            default: cyc_of = rm_cyc(op);
        endcase
    endfunction

    // Blank cells decode as one-byte no-ops with no side effects
    assign mode_w = legal ? mode_of(dec.opcode) : cd8_pkg::CD8_IMPLIED_MODE;
    assign dec.mode = mode_w;
    assign dec.len = cd8_pkg::cd8_len(mode_w);
    assign dec.cycles = legal ? cyc_of(dec.opcode, is_ftest) : cd8_pkg::CD8_CYC_ILLEGAL;
    assign dec.illegal = !legal;
    assign dec.cls = !legal ? cd8_pkg::CD8_CLS_ILLEGAL
        : hi == cd8_pkg::CD8_HI_BIT_BRANCH ? cd8_pkg::CD8_CLS_BIT_BRANCH
        : hi == cd8_pkg::CD8_HI_BIT_SETCLR ? cd8_pkg::CD8_CLS_BIT_SETCLR
        : (hi == cd8_pkg::CD8_HI_BRANCH
            || dec.opcode == cd8_pkg::CD8_OP_BRANCH_TO_SUBROUTINE) ? cd8_pkg::CD8_CLS_BRANCH
        : is_rmw ? cd8_pkg::CD8_CLS_RMW
        : (hi == cd8_pkg::CD8_HI_CTL_A || hi == cd8_pkg::CD8_HI_CTL_B) ? cd8_pkg::CD8_CLS_CONTROL
        : cd8_pkg::CD8_CLS_REGMEM;
    assign dec.upd_nz = is_ftest;
    assign dec.clr_imask = dec.opcode == cd8_pkg::CD8_OP_WAIT;
    assign dec.halt_clk = dec.opcode == cd8_pkg::CD8_OP_WAIT;
    assign dec.copy_x = dec.opcode == cd8_pkg::CD8_OP_COPY_INDEX_TO_ACC;
    assign dec.bit_idx = dec.opcode[3:1];
    assign dec.bit_high = hi == cd8_pkg::CD8_HI_BIT_BRANCH && !dec.opcode[0];
endmodule
`default_nettype wire

// ===== cd8_prog_mem.sv
// Program memory model: queued bytes offered to the decoder fetch port.
// Assumes the bench loads bytes one per cycle and drives stall.
`timescale 1ns/10ps
`default_nettype none
module cd8_prog_mem (
    input wire logic clk_sys,
    input wire logic fetch_ready,
    input wire logic we,
    input wire logic [7:0] wdata,
    input wire logic stall,
    output logic fetch_valid,
    output logic [7:0] fetch_byte
);
    logic [7:0] q[$];
    logic [7:0] last = 8'h00;
    initial begin
        fetch_valid = 1'b0;
        fetch_byte = 8'h00;
    end
    always @(posedge clk_sys) begin
        if (fetch_valid && fetch_ready)
            void'(q.pop_front());
    end
    // Idle bus shows the inverse so a stale byte is never mistaken for data
    always @(negedge clk_sys) begin
        if (we)
            q.push_back(wdata);
        if (!stall && q.size() > 0) begin
            fetch_valid <= 1'b1;
            fetch_byte <= q[0];
            last = q[0];
        end else begin
            fetch_valid <= 1'b0;
            fetch_byte <= ~last;
        end
    end
endmodule
`default_nettype wire

// ===== cd8_opcode_decoder_tb.sv
// Self-checking bench for the opcode decoder, random operands and stalls.
// Assumes cd8_prog_mem as the program memory on the fetch port.
`timescale 1ns/10ps
`default_nettype none
module cd8_opcode_decoder_tb;
    typedef struct {
        logic [7:0] op; logic [2:0] c; logic [3:0] m;
        logic [1:0] l; logic [3:0] y; logic [4:0] f; logic [7:0] b1; logic [7:0] b2;
    } cd8_exp_t;
    logic clk_sys = 1'b0, rst_n = 1'b0, we = 1'b0, stall = 1'b1;
    logic [7:0] wdata = 8'h00, index_reg = 8'h00, fetch_byte, insn_opcode, pc_offset;
    logic fetch_valid, fetch_ready, insn_done, flag_nz_update, imask_clear, cpu_clk_halt;
    logic copy_index_to_acc, opcode_illegal, branch_if_bit_high;
    cd8_pkg::cd8_class_t insn_class;
    cd8_pkg::cd8_mode_t insn_mode;
    logic [1:0] insn_len;
    logic [3:0] insn_cycles;
    logic [2:0] bit_index;
    logic [15:0] operand_addr;
    int fails = 0, checked = 0;
    cd8_exp_t tab[$];
    cd8_opcode_decoder u_dut (.clk_sys, .rst_n, .fetch_valid, .fetch_byte, .index_reg,
        .fetch_ready, .insn_done, .insn_opcode, .insn_class, .insn_mode, .insn_len,
        .insn_cycles, .flag_nz_update, .imask_clear, .cpu_clk_halt, .copy_index_to_acc,
        .opcode_illegal, .bit_index, .branch_if_bit_high, .operand_addr, .pc_offset);
    cd8_prog_mem u_mem (.clk_sys, .fetch_ready, .we, .wdata, .stall, .fetch_valid,
        .fetch_byte);
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    function automatic logic [15:0] exp_addr(input cd8_exp_t e, input logic [7:0] x);
        case (e.m)
            4'h2, 4'h8: exp_addr = {8'h00, e.b1};
            4'h3: exp_addr = {e.b1, e.b2};
            4'h4: exp_addr = {e.b1, e.b2} + {8'h00, x};
            4'h5: exp_addr = {8'h00, e.b1} + {8'h00, x};
            4'h6: exp_addr = {8'h00, x};
            default: exp_addr = 16'h0000;
        endcase
    endfunction
    task automatic add(input logic [7:0] op, input logic [2:0] c, input logic [3:0] m,
        input logic [1:0] l, input logic [3:0] y, input logic [4:0] f);
        tab.push_back('{op, c, m, l, y, f, 8'h00, 8'h00});
    endtask
    // All bytes are queued first so instructions can run back to back
    task automatic run(input logic [7:0] x);
        int n;
        @(negedge clk_sys);
        stall <= 1'b1;
        index_reg <= x;
        foreach (tab[i]) begin
            tab[i].b1 = $urandom_range(255);
            tab[i].b2 = $urandom_range(255);
            for (int k = 0; k < tab[i].l; k++) begin
                we <= 1'b1;
                wdata <= (k == 0) ? tab[i].op : (k == 1) ? tab[i].b1 : tab[i].b2;
                @(negedge clk_sys);
            end
        end
        we <= 1'b0;
        foreach (tab[i]) begin
            n = 0;
            do begin
                @(negedge clk_sys);
                stall <= ($urandom_range(3) == 0);
                n++;
            end while (insn_done !== 1'b1 && n < 40);
            chk(n < 40, 1);
            chk(insn_opcode, tab[i].op);
            chk(insn_class, tab[i].c);
            chk(insn_mode, tab[i].m);
            chk(insn_len, tab[i].l);
            chk(insn_cycles, tab[i].y);
            chk({flag_nz_update, imask_clear, cpu_clk_halt, copy_index_to_acc,
                opcode_illegal}, tab[i].f);
            if (tab[i].m inside {2, 3, 4, 5, 6, 8} || tab[i].c == 6)
                chk(operand_addr, exp_addr(tab[i], x));
            if (tab[i].m inside {7, 8})
                chk(pc_offset, tab[i].m == 7 ? tab[i].b1 : tab[i].b2);
            if (tab[i].c < 2)
                chk(bit_index, tab[i].op[3:1]);
            if (tab[i].c == 0)
                chk(branch_if_bit_high, !tab[i].op[0]);
        end
        $display("test done, index %0h", x);
    endtask
    initial begin
        #(25 * 20000);
        fails++;
        final_report();
    end
    initial begin
        void'($urandom(13013));
        repeat (8) @(negedge clk_sys);
        chk({fetch_ready, insn_class, insn_len}, {1'b0, 3'h6, 2'h1});
        rst_n <= 1'b1;
        @(negedge clk_sys);
        chk(fetch_ready, 1);
        add(8'h3D, 3, 2, 2, 4, 5'h10); add(8'h4D, 3, 0, 1, 3, 5'h10);
        add(8'h5D, 3, 0, 1, 3, 5'h10); add(8'h6D, 3, 5, 2, 5, 5'h10);
        add(8'h7D, 3, 6, 1, 4, 5'h10); add(8'h33, 3, 2, 2, 5, 5'h00);
        add(8'h9F, 4, 0, 1, 2, 5'h02); add(8'h8F, 4, 0, 1, 2, 5'h0C);
        add(8'hAD, 2, 7, 2, 6, 5'h00); add(8'h27, 2, 7, 2, 3, 5'h00);
        add(8'h0E, 0, 8, 3, 5, 5'h00); add(8'h01, 0, 8, 3, 5, 5'h00);
        add(8'h1F, 1, 2, 2, 5, 5'h00); add(8'hC6, 5, 3, 3, 4, 5'h00);
        add(8'hD6, 5, 4, 3, 5, 5'h00); add(8'hE6, 5, 5, 2, 4, 5'h00);
        add(8'h9E, 6, 0, 1, 2, 5'h01); add(8'h31, 6, 0, 1, 2, 5'h01);
        add(8'hA6, 5, 1, 2, 2, 5'h00); add(8'h42, 3, 0, 1, 11, 5'h00);
        add(8'hD7, 5, 4, 3, 6, 5'h00); add(8'hBD, 5, 2, 2, 5, 5'h00);
        add(8'hFC, 5, 6, 1, 2, 5'h00); add(8'h80, 4, 0, 1, 9, 5'h00);
        add(8'hAC, 6, 0, 1, 2, 5'h01);
        run(8'hFF);
        repeat (4) run($urandom_range(255));
        final_report();
    end
endmodule
`default_nettype wire
